// *** logic/kms_scanner.v ***
// Key matrix scanner: 16 sense lines by 8 drive lines, Avalon-MM registers,
// report requests to a downstream transport, one level interrupt.
// Assumes external pads honour the pull-up and output-enable controls.
`timescale 1ns/1ps
`include "kms_regs.vh"
module kms_scanner #(
	parameter TICK_CYCLES = `KMS_TICK_CYCLES,
	parameter SETTLE_CYCLES = `KMS_SETTLE_CYCLES,
	parameter POLL_TICKS = `KMS_POLL_TICKS
) (
	input wire clock_i, // System clock, 50 MHz.
	input wire reset_i, // Asynchronous reset, active high.
	input wire [4:0] avs_address_i, // Avalon byte address.
	input wire avs_read_i, // Avalon read request.
	input wire avs_write_i, // Avalon write request.
	input wire [31:0] avs_writedata_i, // Avalon write data.
	output reg [31:0] avs_readdata_o, // Avalon read data, registered.
	output wire avs_waitrequest_o, // Avalon wait request.
	output wire irq_o, // Level interrupt, high while an unmasked event is set.
	input wire [15:0] key_sense_line_i, // Sense line pin levels.
	output wire [15:0] key_sense_pullup_o, // Sense line pull-up enables.
	output wire [7:0] key_drive_line_o, // Drive line output levels.
	output reg [7:0] key_drive_line_oe_o, // Drive line output enables.
	output wire [7:0] key_drive_pullup_o, // Drive line pull-up enables.
	output reg report_valid_o, // Report request valid.
	input wire report_ready_i, // Transport accepts the report.
	output reg [7:0] report_key_o, // Key identity of the report.
	output reg [7:0] report_mod_o, // Modifier key state of the report.
	output reg report_empty_o // Report is an empty release report.
);

localparam S_IDLE = 4'h0;
localparam S_DEB = 4'h1;
localparam S_FLOAT = 4'h2;
localparam S_DRIVE = 4'h3;
localparam S_LOOK = 4'h4;
localparam S_USE = 4'h5;
localparam S_REP = 4'h6;
localparam S_FIN = 4'h7;
localparam S_REL = 4'h8;
localparam S_END = 4'h9;
localparam S_POLL = 4'hA;

// The counters are 16 and 3 bits wide, so the wider integer values are cut on purpose.
localparam integer TICK_LAST_W = TICK_CYCLES - 1;
localparam integer SETTLE_LAST_W = SETTLE_CYCLES - 1;
localparam integer POLL_LOAD_W = POLL_TICKS;
localparam [15:0] TICK_LAST = TICK_LAST_W[15:0];
localparam [2:0] SETTLE_LAST = SETTLE_LAST_W[2:0];
localparam [15:0] POLL_LOAD = POLL_LOAD_W[15:0];
localparam [7:0] MOD_BASE = `KMS_MOD_BASE;

reg [3:0] state_reg;
reg [2:0] col_reg;
reg [2:0] cnt_reg;
reg [15:0] wait_reg;
reg [6:0] ptr_reg;
reg phase_reg;
reg [127:0] matrix_reg;
reg [127:0] prev_reg;
reg [7:0] mod_reg;
reg tick_rst_reg;
reg [15:0] tick_cnt_reg;
reg irq_en_reg;
reg pend_reg;
reg [3:0] line_reg;
reg [15:0] sense_d_reg;
reg ctrl_en_reg;
reg [15:0] debounce_reg;
reg [3:0] status_reg;
reg [3:0] mask_reg;
reg [6:0] map_addr_reg;
reg ack_reg;
reg [31:0] rd_mux;
reg [3:0] fall_line;
integer k;

wire [15:0] sense_s;
wire [7:0] map_q;
wire [127:0] rowmajor;
wire [15:0] row_multi;
wire [7:0] col_multi;
wire [127:0] ghost;

kms_sync #(
	.WIDTH(16)
) u_sync (
	.clock_i(clock_i),
	.reset_i(reset_i),
	.d_i(key_sense_line_i),
	.q_o(sense_s)
);

wire bus_req = avs_read_i | avs_write_i;
wire wr_fire = ack_reg & avs_write_i;
wire rd_fire = ack_reg & avs_read_i;
wire map_we = wr_fire && (avs_address_i == `KMS_OFS_MAPDATA);

kms_keymap #(
	.AW(7),
	.DW(8)
) u_map (
	.clock_i(clock_i),
	.reset_i(reset_i),
	.wr_en_i(map_we),
	.wr_addr_i(map_addr_reg),
	.wr_data_i(avs_writedata_i[7:0]),
	.rd_addr_i(ptr_reg),
	.rd_data_o(map_q)
);

// Pins: sense lines always pulled up; drive lines drive low when enabled.
assign key_sense_pullup_o = 16'hFFFF;
assign key_drive_line_o = 8'h00;
assign key_drive_pullup_o = ~key_drive_line_oe_o;

// A key is ambiguous when its row and its column each hold another key.
genvar r, c;
generate
	for (c = 0; c < 8; c = c + 1)
	begin : g_col
		wire [15:0] cv = matrix_reg[c*16 +: 16];
		assign col_multi[c] = |(cv & (cv - 16'h0001));
		for (r = 0; r < 16; r = r + 1)
		begin : g_row
			assign rowmajor[r*8+c] = matrix_reg[c*16+r];
			assign ghost[c*16+r] = matrix_reg[c*16+r] & row_multi[r] & col_multi[c];
		end
	end
	for (r = 0; r < 16; r = r + 1)
	begin : g_rm
		wire [7:0] rv = rowmajor[r*8 +: 8];
		assign row_multi[r] = |(rv & (rv - 8'h01));
	end
endgenerate

wire [127:0] valid_keys = matrix_reg & ~ghost;
wire [127:0] new_keys = valid_keys & ~prev_reg;
wire released = |(prev_reg & ~valid_keys);
wire map_is_mod = (map_q[7:3] == MOD_BASE[7:3]);

wire tick = (tick_cnt_reg == TICK_LAST);
wire [15:0] falls = sense_d_reg & ~sense_s & {16{irq_en_reg & ctrl_en_reg}};
wire accept = (state_reg == S_IDLE) && pend_reg && ctrl_en_reg;
wire restore = (state_reg == S_END) && (matrix_reg == 128'h0);

wire ev_wake = accept;
wire ev_press = (state_reg == S_REP) && report_ready_i;
wire ev_rel = (state_reg == S_REL) && report_ready_i;
wire ev_ghost = (state_reg == S_LOOK) && !phase_reg && (ptr_reg == 7'h00) && (|ghost);
wire [3:0] events = {ev_ghost, ev_rel, ev_press, ev_wake};

always @*
begin
	fall_line = 4'h0;
	for (k = 15; k >= 0; k = k - 1)
		if (falls[k])
			fall_line = k[3:0];
end

// Edge flag, captured line and edge enable.
always @(posedge clock_i or posedge reset_i)
begin
	if (reset_i)
	begin
		sense_d_reg <= 16'hFFFF;
		pend_reg <= 1'b0;
		line_reg <= 4'h0;
		irq_en_reg <= 1'b1;
	end
	else
	begin
		sense_d_reg <= sense_s;
		if (|falls)
		begin
			pend_reg <= 1'b1;
			line_reg <= fall_line;
		end
		else if (accept)
			pend_reg <= 1'b0;
		if (accept)
			irq_en_reg <= 1'b0;
		else if (restore)
			irq_en_reg <= 1'b1;
	end
end

// Timer tick prescaler; restarted whenever a tick wait is loaded.
always @(posedge clock_i or posedge reset_i)
begin
	if (reset_i)
		tick_cnt_reg <= 16'h0000;
	else if (tick_rst_reg || tick)
		tick_cnt_reg <= 16'h0000;
	else
		tick_cnt_reg <= tick_cnt_reg + 16'h0001;
end

// Scan sequencer.
always @(posedge clock_i or posedge reset_i)
begin
	if (reset_i)
	begin
		state_reg <= S_IDLE;
		col_reg <= 3'h0;
		cnt_reg <= 3'h0;
		wait_reg <= 16'h0000;
		ptr_reg <= 7'h00;
		phase_reg <= 1'b0;
		matrix_reg <= 128'h0;
		prev_reg <= 128'h0;
		mod_reg <= 8'h00;
		tick_rst_reg <= 1'b0;
		key_drive_line_oe_o <= 8'hFF;
		report_valid_o <= 1'b0;
		report_key_o <= 8'h00;
		report_mod_o <= 8'h00;
		report_empty_o <= 1'b0;
	end
	else
	begin
		tick_rst_reg <= 1'b0;
		case (state_reg)
			S_IDLE:
			begin
				key_drive_line_oe_o <= 8'hFF;
				if (accept)
				begin
					wait_reg <= debounce_reg;
					tick_rst_reg <= 1'b1;
					state_reg <= S_DEB;
				end
			end
			S_DEB:
			begin
				if (wait_reg == 16'h0000)
				begin
					key_drive_line_oe_o <= 8'h00;
					cnt_reg <= 3'h0;
					state_reg <= S_FLOAT;
				end
				else if (tick)
					wait_reg <= wait_reg - 16'h0001;
			end
			S_FLOAT:
			begin
				if (cnt_reg == SETTLE_LAST)
				begin
					col_reg <= 3'h0;
					cnt_reg <= 3'h0;
					key_drive_line_oe_o <= 8'h01;
					state_reg <= S_DRIVE;
				end
				else
					cnt_reg <= cnt_reg + 3'h1;
			end
			S_DRIVE:
			begin
				if (cnt_reg == SETTLE_LAST)
				begin
					matrix_reg[{col_reg, 4'h0} +: 16] <= ~sense_s;
					cnt_reg <= 3'h0;
					if (col_reg == 3'h7)
					begin
						key_drive_line_oe_o <= 8'h00;
						ptr_reg <= 7'h00;
						phase_reg <= 1'b0;
						mod_reg <= 8'h00;
						state_reg <= S_LOOK;
					end
					else
					begin
						col_reg <= col_reg + 3'h1;
						key_drive_line_oe_o <= {key_drive_line_oe_o[6:0], 1'b0};
					end
				end
				else
					cnt_reg <= cnt_reg + 3'h1;
			end
			S_LOOK:
				state_reg <= S_USE;
			S_USE:
			begin
				if (!phase_reg)
				begin
					// First walk gathers the held modifier keys.
					if (valid_keys[ptr_reg] && map_is_mod)
						mod_reg[map_q[2:0]] <= 1'b1;
					if (ptr_reg == 7'h7F)
						phase_reg <= 1'b1;
					ptr_reg <= ptr_reg + 7'h01;
					state_reg <= S_LOOK;
				end
				else if (new_keys[ptr_reg])
				begin
					report_valid_o <= 1'b1;
					report_key_o <= map_q;
					report_mod_o <= mod_reg;
					report_empty_o <= 1'b0;
					state_reg <= S_REP;
				end
				else if (ptr_reg == 7'h7F)
					state_reg <= S_FIN;
				else
				begin
					ptr_reg <= ptr_reg + 7'h01;
					state_reg <= S_LOOK;
				end
			end
			S_REP:
			begin
				if (report_ready_i)
				begin
					report_valid_o <= 1'b0;
					if (ptr_reg == 7'h7F)
						state_reg <= S_FIN;
					else
					begin
						ptr_reg <= ptr_reg + 7'h01;
						state_reg <= S_LOOK;
					end
				end
			end
			S_FIN:
			begin
				// Several releases in one pass collapse into one empty report.
				if (released)
				begin
					report_valid_o <= 1'b1;
					report_key_o <= 8'h00;
					report_mod_o <= mod_reg;
					report_empty_o <= 1'b1;
					state_reg <= S_REL;
				end
				else
					state_reg <= S_END;
			end
			S_REL:
			begin
				if (report_ready_i)
				begin
					report_valid_o <= 1'b0;
					report_empty_o <= 1'b0;
					state_reg <= S_END;
				end
			end
			S_END:
			begin
				prev_reg <= valid_keys;
				if (matrix_reg == 128'h0)
				begin
					key_drive_line_oe_o <= 8'hFF;
					state_reg <= S_IDLE;
				end
				else
				begin
					wait_reg <= POLL_LOAD;
					tick_rst_reg <= 1'b1;
					state_reg <= S_POLL;
				end
			end
			S_POLL:
			begin
				if (wait_reg == 16'h0000)
				begin
					cnt_reg <= 3'h0;
					state_reg <= S_FLOAT;
				end
				else if (tick)
					wait_reg <= wait_reg - 16'h0001;
			end
			default:
				state_reg <= S_IDLE;
		endcase
	end
end

// Register read multiplexer.
always @*
begin
	rd_mux = 32'h0;
	if (avs_address_i == `KMS_OFS_CTRL)
		rd_mux[`KMS_CTRL_EN] = ctrl_en_reg;
	else if (avs_address_i == `KMS_OFS_DEBOUNCE)
		rd_mux[15:0] = debounce_reg;
	else if (avs_address_i == `KMS_OFS_STATUS)
		rd_mux[3:0] = status_reg;
	else if (avs_address_i == `KMS_OFS_MASK)
		rd_mux[3:0] = mask_reg;
	else if (avs_address_i == `KMS_OFS_STATE)
	begin
		rd_mux[3:0] = state_reg;
		rd_mux[`KMS_STATE_LINE_LSB +: 4] = line_reg;
		rd_mux[`KMS_STATE_IRQEN] = irq_en_reg;
		rd_mux[`KMS_STATE_MOD_LSB +: 8] = mod_reg;
	end
	else if (avs_address_i == `KMS_OFS_MAPADDR)
		rd_mux[6:0] = map_addr_reg;
end

assign avs_waitrequest_o = bus_req & ~ack_reg;
assign irq_o = |(status_reg & mask_reg);

// Avalon slave: one wait cycle per access; status bits clear on read.
always @(posedge clock_i or posedge reset_i)
begin
	if (reset_i)
	begin
		ack_reg <= 1'b0;
		avs_readdata_o <= 32'h0;
		ctrl_en_reg <= `KMS_CTRL_RST;
		debounce_reg <= `KMS_DEBOUNCE_RST;
		mask_reg <= `KMS_MASK_RST;
		status_reg <= 4'h0;
		map_addr_reg <= 7'h00;
	end
	else
	begin
		ack_reg <= bus_req & ~ack_reg;
		if (bus_req && !ack_reg)
			avs_readdata_o <= rd_mux;
		// Only bits already returned are cleared; a new event wins.
		if (rd_fire && (avs_address_i == `KMS_OFS_STATUS))
			status_reg <= (status_reg & ~avs_readdata_o[3:0]) | events;
		else
			status_reg <= status_reg | events;
		if (wr_fire)
		begin
			if (avs_address_i == `KMS_OFS_CTRL)
				ctrl_en_reg <= avs_writedata_i[`KMS_CTRL_EN];
			else if (avs_address_i == `KMS_OFS_DEBOUNCE)
				debounce_reg <= avs_writedata_i[15:0];
			else if (avs_address_i == `KMS_OFS_MASK)
				mask_reg <= avs_writedata_i[3:0];
			else if (avs_address_i == `KMS_OFS_MAPADDR)
				map_addr_reg <= avs_writedata_i[6:0];
			else if (avs_address_i == `KMS_OFS_MAPDATA)
				map_addr_reg <= map_addr_reg + 7'h01;
		end
	end
end

endmodule

// *** inc/kms_regs.vh ***
// Constants of the key matrix scanner: register offsets, field positions,
// reset values and timing counts. Assumes a 50 MHz system clock.
`ifndef KMS_REGS_VH
`define KMS_REGS_VH

`define KMS_CLK_HZ 50000000
`define KMS_TICK_US 1000
`define KMS_TICK_CYCLES ((`KMS_CLK_HZ / 1000000) * `KMS_TICK_US)
`define KMS_POLL_MS 4
`define KMS_POLL_TICKS ((`KMS_POLL_MS * 1000) / `KMS_TICK_US)
`define KMS_SETTLE_CYCLES 4

`define KMS_OFS_CTRL 5'h00
`define KMS_OFS_DEBOUNCE 5'h04
`define KMS_OFS_STATUS 5'h08
`define KMS_OFS_MASK 5'h0C
`define KMS_OFS_STATE 5'h10
`define KMS_OFS_MAPADDR 5'h14
`define KMS_OFS_MAPDATA 5'h18

`define KMS_CTRL_EN 0
`define KMS_EV_WAKE 0
`define KMS_EV_PRESS 1
`define KMS_EV_RELEASE 2
`define KMS_EV_GHOST 3
`define KMS_STATE_LINE_LSB 8
`define KMS_STATE_IRQEN 12
`define KMS_STATE_MOD_LSB 16

`define KMS_CTRL_RST 1'h1
`define KMS_DEBOUNCE_RST 16'h0005
`define KMS_MASK_RST 4'h0
`define KMS_MOD_BASE 8'hE0

`endif

// *** logic/kms_sync.v ***
// Two flip-flop synchroniser for a vector of pin inputs.
// Assumes each bit changes independently; idles high after reset.
`timescale 1ns/1ps
module kms_sync #(
	parameter WIDTH = 16
) (
	input wire clock_i, // System clock.
	input wire reset_i, // Asynchronous reset, active high.
	input wire [WIDTH-1:0] d_i, // Asynchronous pin levels.
	output wire [WIDTH-1:0] q_o // Synchronised levels.
);

reg [WIDTH-1:0] s1_reg;
reg [WIDTH-1:0] s2_reg;

always @(posedge clock_i or posedge reset_i)
begin
	if (reset_i)
	begin
		s1_reg <= {WIDTH{1'b1}};
		s2_reg <= {WIDTH{1'b1}};
	end
	else
	begin
		s1_reg <= d_i;
		s2_reg <= s1_reg;
	end
end

assign q_o = s2_reg;

endmodule

// *** logic/kms_keymap.v ***
// Key identity lookup table, one entry per matrix position.
// Assumes one writer; read data come from a register one cycle after the address.
`timescale 1ns/1ps
module kms_keymap #(
	parameter AW = 7,
	parameter DW = 8
) (
	input wire clock_i, // System clock.
	input wire reset_i, // Asynchronous reset, active high.
	input wire wr_en_i, // Write strobe.
	input wire [AW-1:0] wr_addr_i, // Write position.
	input wire [DW-1:0] wr_data_i, // Key identity to store.
	input wire [AW-1:0] rd_addr_i, // Read position.
	output reg [DW-1:0] rd_data_o // Key identity, registered.
);

reg [DW-1:0] mem_reg [0:(1<<AW)-1];
integer i;

// After reset each entry holds its own position as identity.
always @(posedge clock_i or posedge reset_i)
begin
	if (reset_i)
	begin
		for (i = 0; i < (1 << AW); i = i + 1)
			mem_reg[i] <= i[DW-1:0];
		rd_data_o <= {DW{1'b0}};
	end
	else
	begin
		if (wr_en_i)
			mem_reg[wr_addr_i] <= wr_data_i;
		rd_data_o <= mem_reg[rd_addr_i];
	end
end

endmodule

// *** bench/kms_monitor.sv ***
// Port-level protocol monitor for the key matrix scanner.
// Assumes one clock domain with the asynchronous active-high reset.
`timescale 1ns/1ps
module kms_monitor #(
	parameter SETTLE_CYCLES = 4
) (
	input wire clock_i, // System clock.
	input wire reset_i, // Reset.
	input wire avs_read_i, // Bus read.
	input wire avs_write_i, // Bus write.
	input wire avs_waitrequest_o, // Bus wait.
	input wire [15:0] key_sense_pullup_o, // Sense pull-ups.
	input wire [7:0] key_drive_line_o, // Drive levels.
	input wire [7:0] key_drive_line_oe_o, // Drive enables.
	input wire [7:0] key_drive_pullup_o, // Drive pull-ups.
	input wire report_valid_o, // Report valid.
	input wire report_ready_i, // Report ready.
	input wire [7:0] report_key_o, // Report key.
	input wire [7:0] report_mod_o, // Report modifiers.
	input wire report_empty_o // Empty report.
);
	reg [7:0] oe_reg;
	reg [3:0] hold_reg;
	// Counts how long the current drive pattern has stood.
	always @(posedge clock_i or posedge reset_i)
		if (reset_i)
		begin
			oe_reg <= 8'hFF;
			hold_reg <= 4'h0;
		end
		else
		begin
			oe_reg <= key_drive_line_oe_o;
			hold_reg <= (key_drive_line_oe_o != oe_reg) ? 4'h1 : hold_reg + 4'h1;
		end
	default clocking @(posedge clock_i);
	endclocking
	default disable iff (reset_i);
	chk_drive_low: assert property (key_drive_line_o == 8'h00)
		else $error("drive level not low");
	chk_sense_pull: assert property (key_sense_pullup_o == 16'hFFFF)
		else $error("sense pull-up off");
	chk_drive_pull: assert property (key_drive_pullup_o == ~key_drive_line_oe_o)
		else $error("drive pull-up wrong");
	chk_release_first: assert property ($past(key_drive_line_oe_o) == 8'hFF
		&& key_drive_line_oe_o != 8'hFF |-> key_drive_line_oe_o == 8'h00)
		else $error("scan did not release all drive lines");
	chk_one_line: assert property (key_drive_line_oe_o inside {8'hFF, 8'h00}
		|| $onehot(key_drive_line_oe_o))
		else $error("more than one drive line driven");
	chk_scan_order: assert property ($onehot(oe_reg) && oe_reg != 8'h80
		&& key_drive_line_oe_o != oe_reg |-> key_drive_line_oe_o == oe_reg << 1)
		else $error("drive lines out of order");
	chk_step_len: assert property ($onehot(oe_reg)
		&& key_drive_line_oe_o != oe_reg |-> hold_reg == SETTLE_CYCLES)
		else $error("drive step length wrong");
	chk_report_hold: assert property (report_valid_o && !report_ready_i |=>
		report_valid_o && $stable({report_key_o, report_mod_o, report_empty_o}))
		else $error("report changed while waiting");
	chk_report_drop: assert property (report_valid_o && report_ready_i ##1 1
		|-> !report_valid_o)
		else $error("report valid after handshake");
	chk_empty_key: assert property (report_valid_o && report_empty_o
		|-> report_key_o == 8'h00)
		else $error("empty report carries a key");
	chk_bus_wait: assert property ($rose(avs_read_i || avs_write_i)
		|-> avs_waitrequest_o ##1 !avs_waitrequest_o)
		else $error("bus answer timing wrong");
endmodule
bind kms_scanner kms_monitor #(.SETTLE_CYCLES(SETTLE_CYCLES)) kms_monitor_i (
	.clock_i(clock_i), .reset_i(reset_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
	.key_sense_pullup_o(key_sense_pullup_o), .key_drive_line_o(key_drive_line_o),
	.key_drive_line_oe_o(key_drive_line_oe_o), .key_drive_pullup_o(key_drive_pullup_o),
	.report_valid_o(report_valid_o), .report_ready_i(report_ready_i),
	.report_key_o(report_key_o), .report_mod_o(report_mod_o),
	.report_empty_o(report_empty_o)
);

// *** bench/kms_keypad.sv ***
// Passive key switch matrix, index drive*16+sense.
// Assumes sense lines are pulled up whenever nothing pulls them low.
`timescale 1ns/1ps
module kms_keypad (
	input wire [127:0] pressed_i, // Held keys.
	input wire [7:0] drive_oe_i, // Drive enables.
	input wire [7:0] drive_i, // Drive levels.
	output logic [15:0] sense_o // Sense levels.
);
	logic [7:0] drive_low;
	logic [15:0] sense_low;
	// A low level spreads through every pressed key, so three keys in an L show a phantom.
	always_comb
	begin
		drive_low = drive_oe_i & ~drive_i;
		sense_low = 16'h0000;
		for (int n = 0; n < 24; n++)
			for (int d = 0; d < 8; d++)
				for (int s = 0; s < 16; s++)
					if (pressed_i[d * 16 + s] && (drive_low[d] || sense_low[s]))
					begin
						drive_low[d] = 1'b1;
						sense_low[s] = 1'b1;
					end
		sense_o = ~sense_low;
	end
endmodule

// *** bench/kms_scanner_test.sv ***
// Self-checking bench for the key matrix scanner.
// Assumes the keypad model on the pins and the bound monitor.
`timescale 1ns/1ps
module kms_scanner_test;
	localparam TK = 10;
	logic clock_i = 0;
	logic reset_i = 1;
	logic [4:0] avs_address_i = 0;
	logic avs_read_i = 0;
	logic avs_write_i = 0;
	logic [31:0] avs_writedata_i = 0;
	logic report_ready_i = 1;
	logic [127:0] held = 0;
	wire [31:0] avs_readdata_o;
	wire avs_waitrequest_o, irq_o, report_valid_o, report_empty_o;
	wire [15:0] key_sense_line_i, key_sense_pullup_o;
	wire [7:0] key_drive_line_o, key_drive_line_oe_o, key_drive_pullup_o;
	wire [7:0] report_key_o, report_mod_o;
	int fail_count = 0;
	int check_count = 0;
	int cyc = 0;
	int reps = 0;
	int passes = 0;
	logic [7:0] oe_prev = 8'hFF;
	logic [36:0] rows [8] = '{{5'h00, 32'h1}, {5'h04, 32'h5}, {5'h08, 32'h0},
		{5'h0C, 32'h0}, {5'h10, 32'h1000}, {5'h14, 32'h0}, {5'h18, 32'h0}, {5'h1C, 32'h0}};
	kms_scanner #(.TICK_CYCLES(TK), .SETTLE_CYCLES(4), .POLL_TICKS(4)) kms_scanner_i (
		.clock_i, .reset_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
		.avs_readdata_o, .avs_waitrequest_o, .irq_o, .key_sense_line_i, .key_sense_pullup_o,
		.key_drive_line_o, .key_drive_line_oe_o, .key_drive_pullup_o, .report_valid_o,
		.report_ready_i, .report_key_o, .report_mod_o, .report_empty_o);
	kms_keypad kms_keypad_i (.pressed_i(held), .drive_oe_i(key_drive_line_oe_o),
		.drive_i(key_drive_line_o), .sense_o(key_sense_line_i));
	always #10 clock_i = ~clock_i;
	always @(posedge clock_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			results();
		end
	end
	// Counts taken reports and starts of scan passes.
	always @(negedge clock_i)
	begin
		if (report_valid_o && report_ready_i)
			reps++;
		if (key_drive_line_oe_o == 8'h01 && oe_prev != 8'h01)
			passes++;
		oe_prev = key_drive_line_oe_o;
	end
	task results;
		$display("checks=%0d mismatches=%0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clock_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		@(posedge clock_i);
		while (avs_waitrequest_o !== 1'b0)
			@(posedge clock_i);
		q = avs_readdata_o;
		avs_read_i <= 0;
		avs_write_i <= 0;
	endtask
	task w(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task wait_oe(input logic [7:0] v);
		while (key_drive_line_oe_o !== v)
			@(negedge clock_i);
	endtask
	task next_rep(input logic e);
		@(negedge clock_i);
		while (!(report_valid_o === 1'b1 && report_empty_o === e))
			@(negedge clock_i);
	endtask
	initial
	begin
		logic [31:0] q;
		int n;
		repeat (5) @(posedge clock_i);
		reset_i <= 0;
		foreach (rows[i])
		begin
			bus(1'b0, rows[i][36:32], 32'h0, q);
			chk(q, rows[i][31:0]);
		end
		$display("test reset values done");
		w(5'h14, 32'h21);
		w(5'h18, 32'h2A);
		w(5'h18, 32'hE1);
		w(5'h04, 32'h3);
		@(posedge clock_i);
		report_ready_i <= 0;
		held <= (128'h1 << 33) | (128'h1 << 34);
		n = 0;
		@(negedge clock_i);
		while (key_drive_line_oe_o === 8'hFF)
		begin
			@(negedge clock_i);
			n++;
		end
		chk(n >= 3 * TK && n <= 3 * TK + 10, 1);
		bus(1'b0, 5'h10, 0, q);
		chk(q & 32'h1F00, 32'h0100);
		next_rep(1'b0);
		repeat (3) @(negedge clock_i);
		chk({report_key_o, report_mod_o}, 16'h2A02);
		@(posedge clock_i);
		report_ready_i <= 1;
		repeat (1200) @(negedge clock_i);
		chk(irq_o, 0);
		w(5'h0C, 32'hF);
		@(negedge clock_i);
		chk(irq_o, 1);
		bus(1'b0, 5'h08, 0, q);
		chk(q, 32'h3);
		@(negedge clock_i);
		chk(irq_o, 0);
		n = reps;
		@(posedge clock_i);
		held <= 0;
		next_rep(1'b1);
		chk({report_key_o, report_mod_o}, 16'h0000);
		wait_oe(8'hFF);
		chk(reps - n, 1);
		bus(1'b0, 5'h10, 0, q);
		chk(q & 32'h1000, 32'h1000);
		bus(1'b0, 5'h08, 0, q);
		chk(q, 32'h4);
		$display("test press and release done");
		n = reps;
		passes = 0;
		@(posedge clock_i);
		held <= 128'h10003;
		repeat (2000) @(negedge clock_i);
		chk(reps - n, 0);
		chk(passes >= 2, 1);
		bus(1'b0, 5'h08, 0, q);
		chk(q, 32'h9);
		// Release after the drive steps, so that no pass samples half of the ghost pattern.
		wait_oe(8'h80);
		wait_oe(8'h00);
		@(posedge clock_i);
		held <= 0;
		wait_oe(8'hFF);
		chk(reps - n, 0);
		$display("test ghost keys done");
		w(5'h00, 32'h0);
		@(posedge clock_i);
		held <= 128'h1;
		repeat (100) @(negedge clock_i);
		chk(key_drive_line_oe_o, 8'hFF);
		@(posedge clock_i);
		held <= 0;
		w(5'h00, 32'h1);
		@(posedge clock_i);
		held <= 128'h1;
		wait_oe(8'h01);
		@(posedge clock_i);
		reset_i <= 1;
		@(negedge clock_i);
		chk({key_drive_line_oe_o, report_valid_o, irq_o}, 10'h3FC);
		@(posedge clock_i);
		reset_i <= 0;
		held <= 0;
		$display("test disable and reset done");
		results();
	end
endmodule
